// >>> bench/cpp_printer_model.sv
// Behavioural printer that sits on the far side of the port lines
`timescale 1ns/1ps
module cpp_printer_model (
  // Levels commanded by the bench
  input wire cpp_pkg::cpp_lines_t lines_set,
  input wire logic [7:0] rev_byte,
  // Port side
  input wire logic [7:0] port_data_lines_out,
  input wire logic port_data_lines_oe,
  output cpp_pkg::cpp_lines_t periph_lines,
  output logic [7:0] port_data_lines_in
);
  import cpp_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Status levels are held exactly as commanded
  assign periph_lines = lines_set;
  // Drives the data lines only once the port lets go, so a stale byte cannot pass for a read
  assign port_data_lines_in = port_data_lines_oe ? port_data_lines_out : rev_byte;
endmodule

// >>> bench/test_compat_parallel_port_regs.sv
// Self-checking bench for the parallel port register bank
`timescale 1ns/1ps
`include "cpp_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_compat_parallel_port_regs;
  import cpp_pkg::*;
  localparam logic [9:0] B0 = `CPP_BASE_378;
  localparam logic [9:0] B1 = B0 + 10'h1;
  localparam logic [9:0] B2 = B0 + 10'h2;
  localparam logic [9:0] B3 = B0 + 10'h3;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hard_reset_input = 1'b0;
  cpp_mode_t port_mode = CPP_MODE_STD;
  cpp_base_t port_base = CPP_BASE_LPT1;
  cpp_req_t io_req = '0;
  logic rsp_ready = 1'b0;
  cpp_lines_t lines = 5'h0b;
  logic [7:0] rev_byte = 8'h3c;
  logic io_ready, rsp_valid, port_data_lines_oe, port_irq;
  logic [7:0] rsp_data, pd_in, pd_out;
  logic [3:0] ctl_n;
  cpp_lines_t periph_lines;
  int err_count = 0;
  int n_compared = 0;

  always #2.5 clk_sys = ~clk_sys;

  cpp_regs DUT (.clk_sys(clk_sys), .reset(reset), .hard_reset_input(hard_reset_input),
    .port_mode(port_mode), .port_base(port_base), .io_req(io_req), .io_ready(io_ready),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
    .port_data_lines_in(pd_in), .port_data_lines_out(pd_out),
    .port_data_lines_oe(port_data_lines_oe), .periph_lines(periph_lines),
    .strobe_n(ctl_n[0]), .autofd_n(ctl_n[1]), .init_n(ctl_n[2]), .selectin_n(ctl_n[3]),
    .port_irq(port_irq));

  cpp_printer_model PRN (.lines_set(lines), .rev_byte(rev_byte),
    .port_data_lines_out(pd_out), .port_data_lines_oe(port_data_lines_oe),
    .periph_lines(periph_lines), .port_data_lines_in(pd_in));

  ////////////////////////////////////////////////////////////////////////////////
  // Request held until io_ready is seen, released the cycle after it is taken
  task automatic issue(input logic rd, input logic [9:0] a, input logic [7:0] d);
    int g;
    @(negedge clk_sys);
    io_req = {rd, ~rd, a, d};
    for (g = 0; g < 20 && io_ready !== 1'b1; g++) @(negedge clk_sys);
    @(negedge clk_sys);
    io_req = '0;
  endtask

  task automatic take(input logic [7:0] e);
    int g;
    for (g = 0; g < 20 && rsp_valid !== 1'b1; g++) @(negedge clk_sys);
    `CHK(rsp_data, e)
    rsp_ready = 1'b1;
    @(negedge clk_sys);
    rsp_ready = 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    issue(1'b0, a, d);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    issue(1'b1, a, 8'h00);
    take(e);
  endtask

  // Pin changes need the synchroniser to catch up
  task automatic settle;
    repeat (6) @(negedge clk_sys);
  endtask

  task automatic ack_pulse;
    lines.ack_n = 1'b0;
    settle();
    lines.ack_n = 1'b1;
    settle();
  endtask

  function automatic logic [9:0] badr(input cpp_base_t b);
    return b == CPP_BASE_LPT2 ? `CPP_BASE_278 : b == CPP_BASE_MONO ? `CPP_BASE_3BC : B0;
  endfunction

  function automatic logic [7:0] stat(input cpp_lines_t l, input logic f);
    return {~l.busy, l.ack_n, l.perror, l.select, l.fault_n, f, 2'h0};
  endfunction

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    `CHK(pd_out, 8'h00)
    `CHK(port_data_lines_oe, 1'b1)
    `CHK(ctl_n, 4'hb)
    rd(B0, 8'h00);
    rd(B1, 8'hdc);
    rd(B2, 8'h00);
    wr(B0, 8'ha5);
    `CHK(pd_out, 8'ha5)
    rd(B0, 8'ha5);
    wr(B1, 8'h5a);
    `CHK(pd_out, 8'ha5)
    rd(B1, 8'hdc);
    rd(B3, `CPP_UNMAPPED);
    // Interrupt enabled but standard mode must keep the flag at one
    wr(B2, 8'h1f);
    `CHK(ctl_n, 4'h4)
    for (int i = 0; i < 5; i++) begin
      lines = 5'h0b ^ (5'h01 << i);
      settle();
      rd(B1, stat(lines, 1'b1));
    end
    lines = 5'h0b;
    settle();
    rd(B1, 8'hdc);
    `CHK(port_irq, 1'b0)
    for (int m = 0; m < 4; m++) begin
      port_mode = cpp_mode_t'(m);
      for (int b = 1; b < 4; b++) begin
        port_base = cpp_base_t'(b);
        wr(badr(port_base), 8'h40 + 8'(b));
        rd(badr(port_base), (m >= 2 && b == 3) ? `CPP_UNMAPPED : 8'h40 + 8'(b));
      end
    end
    port_base = CPP_BASE_OFF;
    rd(B0, `CPP_UNMAPPED);
    port_base = CPP_BASE_LPT1;
    port_mode = CPP_MODE_BIDIR;
    wr(B0, 8'h5a);
    `CHK(pd_out, 8'h5a)
    wr(B2, 8'hf0);
    `CHK(port_data_lines_oe, 1'b0)
    rd(B2, 8'h30);
    settle();
    rd(B0, 8'h3c);
    wr(B2, 8'h10);
    `CHK(port_data_lines_oe, 1'b1)
    rd(B0, 8'h5a);
    ack_pulse();
    `CHK(port_irq, 1'b1)
    rd(B1, stat(lines, 1'b0));
    rd(B1, stat(lines, 1'b1));
    `CHK(port_irq, 1'b0)
    wr(B2, 8'h00);
    ack_pulse();
    `CHK(port_irq, 1'b0)
    rd(B1, stat(lines, 1'b1));
    wr(B2, 8'h10);
    ack_pulse();
    hard_reset_input = 1'b1;
    settle();
    hard_reset_input = 1'b0;
    settle();
    `CHK(pd_out, 8'h00)
    `CHK(port_irq, 1'b0)
    rd(B2, 8'h00);
    // Host stalls: two answers fill the buffer, then both drain intact
    issue(1'b1, B0, 8'h00);
    issue(1'b1, B1, 8'h00);
    `CHK(io_ready, 1'b0)
    take(8'h00);
    take(stat(lines, 1'b1));
    tally_and_finish();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    tally_and_finish();
  end
endmodule

// >>> logic/cpp_buf2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module cpp_buf2 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [2];
  logic wp;
  logic rp;
  logic [1:0] cnt;
  logic push;
  logic pop;

  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else if (flush) begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push) begin
        wp <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule

// >>> logic/cpp_params.svh
// Offsets, field positions, reset values and timing counts of the port register bank
`ifndef CPP_PARAMS_SVH
`define CPP_PARAMS_SVH

`define CPP_OFS_DATA 2'h0
`define CPP_OFS_STATUS 2'h1
`define CPP_OFS_CONTROL 2'h2

`define CPP_BASE_378 10'h378
`define CPP_BASE_278 10'h278
`define CPP_BASE_3BC 10'h3bc

`define CPP_ST_BUSY 7
`define CPP_ST_ACK 6
`define CPP_ST_PERR 5
`define CPP_ST_SEL 4
`define CPP_ST_FAULT 3
`define CPP_ST_IRQ 2

`define CPP_CT_DIR 5
`define CPP_CT_ACKIEN 4
`define CPP_CT_SELIN 3
`define CPP_CT_INIT 2
`define CPP_CT_AUTOFD 1
`define CPP_CT_STROBE 0

`define CPP_RST_DATA 8'h00
`define CPP_RST_CONTROL 8'h00
`define CPP_UNMAPPED 8'hff
`define CPP_SYNC_STAGES 2

`endif

// >>> logic/cpp_pkg.sv
// Types shared by the parallel port register bank
package cpp_pkg;

  typedef enum logic [1:0] {
    CPP_MODE_STD = 2'h0,
    CPP_MODE_BIDIR = 2'h1,
    CPP_MODE_EPP = 2'h2,
    CPP_MODE_ECP = 2'h3
  } cpp_mode_t;

  typedef enum logic [1:0] {
    CPP_BASE_OFF = 2'h0,
    CPP_BASE_LPT1 = 2'h1,
    CPP_BASE_LPT2 = 2'h2,
    CPP_BASE_MONO = 2'h3
  } cpp_base_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } cpp_req_t;

  typedef struct packed {
    logic busy;
    logic ack_n;
    logic perror;
    logic select;
    logic fault_n;
  } cpp_lines_t;

endpackage

// >>> logic/cpp_regs.sv
// Data, status and control registers of a compatible parallel port
`timescale 1ns/1ps
`include "cpp_params.svh"

// What this block does
// RULE_01: Registers are single bytes on an 8-bit host port; no wider access.
// RULE_02: Base selectable off, 378h, 278h; 3BCh only in standard and bidirectional.
// RULE_03: Hard reset loads every register with its default.
// RULE_04: Writes to read-only status are accepted and change nothing.
// RULE_05: Data register at offset 00h, read/write, 8 bits, resets to 00h.
// RULE_06: Status at offset 01h, read-only, bit 2 one after reset, 1:0 reserved.
// RULE_07: Standard mode drives the stored data byte onto the port lines continuously.
// RULE_08: Standard mode data read completes and returns the stored byte.
// RULE_09: Software should not read data register in standard mode.
// RULE_10: Bidirectional with direction 0: write stores and drives the byte.
// RULE_11: Bidirectional with direction 1: read returns live lines, register unchanged.
// RULE_12: Status bit 7 is busy inverted.
// RULE_13: Status bit 6 follows acknowledge line level.
// RULE_14: Status bit 5 follows paper error true-sense.
// RULE_15: Status bit 4 follows select true-sense.
// RULE_16: Status bit 3 follows fault line level.
// RULE_17: Standard mode status bit 2 always reads one.
// RULE_18: Bidirectional, enabled: acknowledge rising edge clears flag and raises interrupt.
// RULE_19: Flag returns to one on status read and on hard reset.
// RULE_20: With acknowledge interrupt disabled, flag never clears.
// RULE_21: Software masks reserved bits on read and preserves them on write.
// RULE_22: Control bit 4 enables the acknowledge interrupt.
// RULE_23: Bidirectional: control bit 5 zero drives lines, one releases them.
// RULE_24: Peripheral inputs are synchronised before use.
module cpp_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hard_reset_input,
  // Configuration
  input wire cpp_pkg::cpp_mode_t port_mode,
  input wire cpp_pkg::cpp_base_t port_base,
  // Host request
  input wire cpp_pkg::cpp_req_t io_req,
  output logic io_ready,
  // Host read answer
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_data,
  // Port data lines
  input wire logic [7:0] port_data_lines_in,
  output logic [7:0] port_data_lines_out,
  output logic port_data_lines_oe,
  // Peripheral status lines
  input wire cpp_pkg::cpp_lines_t periph_lines,
  // Control lines and interrupt
  output logic strobe_n,
  output logic autofd_n,
  output logic init_n,
  output logic selectin_n,
  output logic port_irq
);
  import cpp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers

  logic hard_rst;
  logic [7:0] pd_live;
  cpp_lines_t lines;
  logic ack_prev;
  logic ack_rise;
  logic [4:0] lines_q;

  // Acknowledge crosses inverted so a cleared synchroniser reads as an idle high line;
  // a plain zero there would look like a trailing acknowledge edge just after reset
  localparam logic [4:0] ACK_FLIP = 5'h08;

  cpp_sync #(.W(1)) u_sync_rst (
    .clk_sys(clk_sys),
    .reset(reset),
    .d(hard_reset_input),
    .q(hard_rst)
  );

  // Pin levels cross two flops before any status or edge logic sees them
  cpp_sync #(.W(13)) u_sync_pins ( // RULE_24
    .clk_sys(clk_sys),
    .reset(reset),
    .d({port_data_lines_in, periph_lines ^ ACK_FLIP}),
    .q({pd_live, lines_q})
  );

  assign lines = cpp_lines_t'(lines_q ^ ACK_FLIP);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_prev <= 1'b1;
    end else begin
      ack_prev <= lines.ack_n;
    end
  end

  // Acknowledge interrupt fires on the trailing low-to-high edge
  assign ack_rise = lines.ack_n && !ack_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic bidir;
  logic base_ok;
  logic [9:0] base_addr;
  logic hit;
  logic [1:0] ofs;
  logic take;
  logic rd_take;
  logic wr_take;

  assign bidir = (port_mode != CPP_MODE_STD);

  always_comb begin
    base_ok = 1'b1;
    base_addr = `CPP_BASE_378;
    case (port_base)
      CPP_BASE_LPT1: base_addr = `CPP_BASE_378; // RULE_02
      CPP_BASE_LPT2: base_addr = `CPP_BASE_278; // RULE_02
      CPP_BASE_MONO: begin
        base_addr = `CPP_BASE_3BC;
        base_ok = (port_mode == CPP_MODE_STD) || (port_mode == CPP_MODE_BIDIR); // RULE_02
      end
      default: base_ok = 1'b0;
    endcase
  end

  assign ofs = io_req.addr[1:0];
  // Three registers per base; offset 3 is outside the bank
  assign hit = base_ok && (io_req.addr[9:2] == base_addr[9:2]) && (ofs != 2'h3);
  assign take = (io_req.rd || io_req.wr) && io_ready;
  // Byte-only port: one register per access, never a wider word
  assign rd_take = take && io_req.rd; // RULE_01
  assign wr_take = take && io_req.wr && !io_req.rd;

  ////////////////////////////////////////////////////////////////////////////
  // Data register

  logic [7:0] port_data_byte;
  logic wr_data;

  assign wr_data = wr_take && hit && (ofs == `CPP_OFS_DATA); // RULE_04

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_data_byte <= `CPP_RST_DATA;
    end else if (hard_rst) begin
      port_data_byte <= `CPP_RST_DATA; // RULE_03
    end else if (wr_data) begin
      port_data_byte <= io_req.wdata; // RULE_05 RULE_10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic [7:0] port_line_control;
  logic acknowledge_interrupt_enable;
  logic dir_in;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_line_control <= `CPP_RST_CONTROL;
    end else if (hard_rst) begin
      port_line_control <= `CPP_RST_CONTROL; // RULE_03
    end else if (wr_take && hit && (ofs == `CPP_OFS_CONTROL)) begin
      port_line_control <= {2'h0, io_req.wdata[5:0]};
    end
  end

  assign acknowledge_interrupt_enable = port_line_control[`CPP_CT_ACKIEN]; // RULE_22
  // Direction bit only matters outside standard mode
  assign dir_in = bidir && port_line_control[`CPP_CT_DIR]; // RULE_23

  assign strobe_n = ~port_line_control[`CPP_CT_STROBE];
  assign autofd_n = ~port_line_control[`CPP_CT_AUTOFD];
  assign init_n = port_line_control[`CPP_CT_INIT];
  assign selectin_n = ~port_line_control[`CPP_CT_SELIN];

  ////////////////////////////////////////////////////////////////////////////
  // Port data pins

  assign port_data_lines_out = port_data_byte; // RULE_07 RULE_10
  assign port_data_lines_oe = !dir_in; // RULE_07 RULE_23

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flag

  logic port_interrupt_flag;
  logic rd_status;
  logic ack_event;

  assign rd_status = rd_take && hit && (ofs == `CPP_OFS_STATUS);
  assign ack_event = bidir && acknowledge_interrupt_enable && ack_rise; // RULE_18 RULE_20

  // Flag is active low; an edge landing on a status read still clears it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_interrupt_flag <= 1'b1;
    end else if (hard_rst) begin
      port_interrupt_flag <= 1'b1; // RULE_19
    end else if (ack_event) begin
      port_interrupt_flag <= 1'b0; // RULE_18
    end else if (rd_status) begin
      port_interrupt_flag <= 1'b1; // RULE_19
    end
  end

  assign port_irq = bidir && !port_interrupt_flag; // RULE_18

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] port_line_status;
  logic [7:0] rd_value;

  always_comb begin
    port_line_status = 8'h00;
    port_line_status[`CPP_ST_BUSY] = ~lines.busy; // RULE_12
    port_line_status[`CPP_ST_ACK] = lines.ack_n; // RULE_13
    port_line_status[`CPP_ST_PERR] = lines.perror; // RULE_14
    port_line_status[`CPP_ST_SEL] = lines.select; // RULE_15
    port_line_status[`CPP_ST_FAULT] = lines.fault_n; // RULE_16
    port_line_status[`CPP_ST_IRQ] = bidir ? port_interrupt_flag : 1'b1; // RULE_06 RULE_17
  end

  always_comb begin
    rd_value = `CPP_UNMAPPED;
    if (hit) begin
      case (ofs)
        `CPP_OFS_DATA: rd_value = dir_in ? pd_live : port_data_byte; // RULE_08 RULE_11
        `CPP_OFS_STATUS: rd_value = port_line_status; // RULE_06
        `CPP_OFS_CONTROL: rd_value = port_line_control;
        default: rd_value = `CPP_UNMAPPED;
      endcase
    end
  end

  // Host stall backs up into the request side instead of dropping answers
  cpp_buf2 #(.W(8)) u_rsp_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .flush(hard_rst),
    .in_valid(rd_take),
    .in_ready(io_ready),
    .in_data(rd_value),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  AST_HARD_RESET: assert property (hard_rst |=> port_data_byte == 8'h00 && // RULE_03
      port_line_control == 8'h00 && port_interrupt_flag)
    else $error("hard reset did not load defaults");

  AST_RO_WRITE: assert property (wr_take && hit && ofs == `CPP_OFS_STATUS && // RULE_04
      !hard_rst |=> $stable(port_data_byte) && $stable(port_line_control))
    else $error("status write changed port state");

  AST_DATA_WRITE: assert property (wr_data && !hard_rst |=> // RULE_05
      port_data_lines_out == $past(io_req.wdata))
    else $error("data write not driven on lines");

  AST_STD_DRIVE: assert property (port_mode == CPP_MODE_STD |-> // RULE_07
      port_data_lines_oe && port_data_lines_out == port_data_byte)
    else $error("standard mode not driving data lines");

  AST_DIR_RELEASE: assert property (bidir && port_line_control[5] |-> // RULE_23
      !port_data_lines_oe)
    else $error("lines driven while direction is input");

  AST_STD_READ: assert property (rd_take && hit && ofs == 2'h0 && !dir_in && // RULE_08
      !rsp_valid |=> rsp_valid && rsp_data == $past(port_data_byte))
    else $error("standard data read wrong");

  AST_LIVE_READ: assert property (rd_take && hit && ofs == 2'h0 && dir_in && // RULE_11
      !rsp_valid |=> rsp_data == $past(pd_live) && $stable(port_data_byte))
    else $error("reverse read wrong");

  AST_STD_BIT2: assert property (rd_status && port_mode == CPP_MODE_STD && // RULE_17
      !rsp_valid |=> rsp_data[2] && rsp_data[1:0] == 2'h0)
    else $error("status bit 2 not one in standard mode");

  AST_BUSY_INV: assert property (rd_status && !rsp_valid |=> // RULE_12
      rsp_data[7] == !$past(lines.busy) && rsp_data[6] == $past(lines.ack_n))
    else $error("busy or ack status wrong");

  AST_ACK_CLEAR: assert property (ack_event && !hard_rst |=> // RULE_18
      !port_interrupt_flag && port_irq)
    else $error("ack edge did not raise interrupt");

  AST_READ_SET: assert property (rd_status && !ack_event && !hard_rst |=> // RULE_19
      port_interrupt_flag)
    else $error("status read did not restore flag");

  AST_DIS_HOLD: assert property (!acknowledge_interrupt_enable && port_interrupt_flag // RULE_20
      |=> port_interrupt_flag)
    else $error("flag cleared while disabled");

  AST_ACK_BIT: assert property (rd_status && !rsp_valid && !hard_rst |=> // RULE_13
      rsp_data[`CPP_ST_ACK] == $past(lines.ack_n))
    else $error("acknowledge status bit wrong");

  AST_PERR_BIT: assert property (rd_status && !rsp_valid && !hard_rst |=> // RULE_14
      rsp_data[`CPP_ST_PERR] == $past(lines.perror))
    else $error("paper error status bit wrong");

  AST_SEL_BIT: assert property (rd_status && !rsp_valid && !hard_rst |=> // RULE_15
      rsp_data[`CPP_ST_SEL] == $past(lines.select))
    else $error("select status bit wrong");

  AST_FAULT_BIT: assert property (rd_status && !rsp_valid && !hard_rst |=> // RULE_16
      rsp_data[`CPP_ST_FAULT] == $past(lines.fault_n))
    else $error("fault status bit wrong");

  AST_RSVD_ZERO: assert property (rd_status && !rsp_valid && !hard_rst |=> // RULE_06
      rsp_data[1:0] == 2'h0)
    else $error("reserved status bits not zero");

  AST_BIDIR_WRITE: assert property (bidir && !dir_in && wr_data && !hard_rst |=> // RULE_10
      port_data_lines_oe && port_data_lines_out == $past(io_req.wdata))
    else $error("forward write not driven in bidirectional mode");

  AST_FLAG_HARD: assert property (hard_rst |=> // RULE_19
      port_interrupt_flag && !port_irq)
    else $error("hard reset did not restore interrupt flag");

  AST_IRQ_STD: assert property (port_mode == CPP_MODE_STD |-> // RULE_17
      !port_irq && port_line_status[`CPP_ST_IRQ])
    else $error("interrupt reported in standard mode");

  AST_EN_GATE: assert property (bidir && acknowledge_interrupt_enable && ack_rise && // RULE_22
      !hard_rst |=> !port_interrupt_flag)
    else $error("enabled acknowledge edge ignored");

  COV_ACK_IRQ: cover property (ack_event ##[1:20] rd_status);
  COV_REVERSE: cover property (rd_take && hit && ofs == 2'h0 && dir_in);
  COV_STALL: cover property (rsp_valid && !rsp_ready && !io_ready);
  COV_MONO: cover property (port_base == CPP_BASE_MONO && wr_data);
  COV_DIS_EDGE: cover property (bidir && !acknowledge_interrupt_enable && ack_rise);

endmodule

// >>> logic/cpp_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module cpp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // Only the second stage is visible to the rest of the design
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
